// ### frpec_regs.svh
`ifndef FRPEC_REGS_SVH
`define FRPEC_REGS_SVH
// register word addresses on the core port
`define FRPEC_ADDR_CTRL      4'h0
`define FRPEC_ADDR_ADRL      4'h1
`define FRPEC_ADDR_ADRU      4'h2
`define FRPEC_ADDR_KEY       4'h3
`define FRPEC_ADDR_PAGE      4'h4
`define FRPEC_ADDR_STATUS    4'h5
`define FRPEC_ADDR_IRQ_EN    4'h6
`define FRPEC_ADDR_IRQ_CLR   4'h7
// control field positions
`define FRPEC_CTRL_START_BIT 15
`define FRPEC_CTRL_FLASH_WRITE_ENABLE_BIT_BIT  14
`define FRPEC_OP_MSB         3
`define FRPEC_OP_ERASE       4'h3
`define FRPEC_OP_ROW         4'h2
// unlock key values
`define FRPEC_KEY_FIRST      16'h0055
`define FRPEC_KEY_SECOND     16'h00aa
// reset values
`define FRPEC_CTRL_RST       16'h0000
`define FRPEC_PAGE_RST       8'h00
// latch page selector and geometry
`define FRPEC_LATCH_PAGE     8'hfa
`define FRPEC_ROW_WORDS      128
`define FRPEC_BLOCK_ROWS     8
// status bit positions
`define FRPEC_ST_DONE        0
`define FRPEC_ST_REJECT      1
`define FRPEC_ST_SEC         2
`define FRPEC_ST_DED         3
`endif

// ### frpec_pkg.sv
`default_nettype none
package frpec_pkg;
   // sequencer states, gray along idle-erase/row-done
   typedef enum logic [1:0]
   {
      FRPEC_IDLE  = 2'b00,
      FRPEC_ERASE = 2'b01,
      FRPEC_ROW   = 2'b11,
      FRPEC_DONE  = 2'b10
   } frpec_state_t;
   // table operation kinds
   typedef enum logic [1:0]
   {
      FRPEC_TBL_NONE = 2'b00,
      FRPEC_TBL_LOW  = 2'b01,
      FRPEC_TBL_HIGH = 2'b10
   } frpec_tbl_t;
endpackage
`default_nettype wire

// ### frpec_ecc.sv
`default_nettype none
// 7-bit secded over 24 data bits: hamming syndrome plus overall parity
module frpec_ecc
(
   // data to protect and its stored check bits
   input  wire logic [23:0] i_data,
   input  wire logic [6:0]  i_par,
   // generated check bits and decode results
   output logic      [6:0]  o_par,
   output logic      [23:0] o_fixed,
   output logic             o_sec,
   output logic             o_ded
);
   logic [5:0] synd;   // hamming syndrome of stored word
   logic       ovl;    // overall parity mismatch
   // hamming code position of data bit k
   function automatic logic [5:0] pos_of(input int k);
      int p;
      int d;
      p = 0;
      d = -1;
      for (int n = 1; n < 64; n++)
      begin
         if ((n & (n - 1)) != 0 && d < k)
         begin
            d = d + 1;
            p = n;
         end
      end
      return p[5:0];
   endfunction
   // parity generation over hamming positions
   always_comb
   begin
      o_par = 7'h00;
      for (int k = 0; k < 24; k++)
      begin
         o_par[5:0] = o_par[5:0] ^ (i_data[k] ? pos_of(k) : 6'h00);
      end
      o_par[6] = ^{i_data, o_par[5:0]};
   end
   // syndrome check and single-bit correction
   always_comb
   begin
      synd = 6'h00;
      for (int k = 0; k < 24; k++)
      begin
         synd = synd ^ (i_data[k] ? pos_of(k) : 6'h00);
      end
      synd = synd ^ i_par[5:0];
      ovl  = ^{i_data, i_par};
      o_fixed = i_data;
      for (int k = 0; k < 24; k++)
      begin
         if (ovl && synd == pos_of(k))
         begin
            o_fixed[k] = ~i_data[k];
         end
      end
      o_sec = ovl;
      o_ded = !ovl && (synd != 6'h00);
   end
endmodule
`default_nettype wire

// ### frpec_top.sv
// Decided for this implementation: the register offsets and the plain strobed port.
`include "frpec_regs.svh"
`default_nettype none
module frpec_top
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // register port
   input  wire logic [3:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [15:0] o_rdata,
   // table operations from the core
   input  wire logic        i_tbl_rd,
   input  wire logic        i_tbl_wr,
   input  wire logic        i_tbl_high,
   input  wire logic        i_tbl_byte,
   input  wire logic        i_tbl_ea0,
   input  wire logic [15:0] i_tbl_ea,
   input  wire logic [15:0] i_tbl_wdata,
   output logic      [15:0] o_tbl_rdata,
   // core stall, trap and interrupt
   output logic             o_stall,
   output logic             o_dbe_trap,
   output logic             o_irq,
   // flash array side
   output logic      [23:0] o_fl_addr,
   output logic      [23:0] o_fl_wdata,
   output logic      [6:0]  o_fl_wpar,
   output logic             o_fl_prog,
   output logic             o_fl_erase,
   input  wire logic [23:0] i_fl_rdata,
   input  wire logic [6:0]  i_fl_rpar,
   input  wire logic        i_fl_busy
);
   localparam int ROWN = `FRPEC_ROW_WORDS;
   // registers
   logic [15:0] ctrl;                   // control register
   logic [15:0] adr_lo;                 // flash address lower
   logic [7:0]  adr_hi;                 // flash address upper
   logic [7:0]  page;                   // table page register
   logic [1:0]  key_stage;              // unlock tracking
   logic [3:0]  status;                 // sticky events
   logic [3:0]  irq_en;                 // event enables
   logic [23:0] latch [ROWN];           // programming latches
   logic [6:0]  widx;                   // word index during row write
   logic [1:0]  busy_s;                 // busy synchroniser
   frpec_pkg::frpec_state_t state;      // sequencer state
   frpec_pkg::frpec_state_t next_state;
   // decodes
   wire         wr_ctrl  = i_wr && i_addr == `FRPEC_ADDR_CTRL;
   wire         wr_key   = i_wr && i_addr == `FRPEC_ADDR_KEY;
   wire         unlocked = key_stage == 2'd2;
   wire [3:0]   op       = ctrl[`FRPEC_OP_MSB:0];
   wire         start_rq = wr_ctrl && i_wdata[`FRPEC_CTRL_START_BIT] && state == frpec_pkg::FRPEC_IDLE;
   wire         op_ok    = i_wdata[3:0] == `FRPEC_OP_ERASE || i_wdata[3:0] == `FRPEC_OP_ROW;
   wire         go       = start_rq && unlocked && i_wdata[`FRPEC_CTRL_FLASH_WRITE_ENABLE_BIT_BIT] && op_ok;
   wire         reject   = start_rq && !go;
   wire [23:0]  tbl_addr = {page, i_tbl_ea};
   wire         to_latch = page == `FRPEC_LATCH_PAGE;
   wire [6:0]   lidx     = i_tbl_ea[7:1];
   wire         fl_busy  = busy_s[1];
   wire         seq_end  = state == frpec_pkg::FRPEC_DONE;
   wire [23:0]  ecc_fixed;              // corrected array word
   wire         ecc_sec;
   wire         ecc_ded;
   wire [6:0]   ecc_par;
   wire [23:0]  rd_word  = to_latch ? latch[lidx] : ecc_fixed;
   wire         rd_flash = i_tbl_rd && !to_latch;
   // idle: decode what the array returns; in a cycle: code the word being written
   wire [23:0]  ecc_in   = state == frpec_pkg::FRPEC_IDLE ? i_fl_rdata : o_fl_wdata;
   logic [7:0]  words_done;             // words handed over in this row, checker only

   // ecc generate on program data, check on read data
   frpec_ecc u_ecc
   (
      .i_data  (ecc_in),
      .i_par   (i_fl_rpar),
      .o_par   (ecc_par),
      .o_fixed (ecc_fixed),
      .o_sec   (ecc_sec),
      .o_ded   (ecc_ded)
   );

   // busy from the array crosses through two flops
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         busy_s <= 2'b00;
      else
         busy_s <= {busy_s[0], i_fl_busy};
   end

   // unlock tracking: any other write drops it
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         key_stage <= 2'd0;
      else if (wr_key && i_wdata == `FRPEC_KEY_FIRST)
         key_stage <= 2'd1;
      else if (wr_key && i_wdata == `FRPEC_KEY_SECOND && key_stage == 2'd1)
         key_stage <= 2'd2;
      else if (i_wr)
         key_stage <= 2'd0;
   end

   // register writes; start bit only held while a cycle runs
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         ctrl   <= `FRPEC_CTRL_RST;
         adr_lo <= 16'h0000;
         adr_hi <= 8'h00;
         page   <= `FRPEC_PAGE_RST;
         irq_en <= 4'h0;
      end
      else
      begin
         if (wr_ctrl && state == frpec_pkg::FRPEC_IDLE)
            ctrl <= {go, i_wdata[14:0]};
         else if (seq_end)
            ctrl[`FRPEC_CTRL_START_BIT] <= 1'b0;
         if (i_wr && i_addr == `FRPEC_ADDR_ADRL)
            adr_lo <= i_wdata;
         if (i_wr && i_addr == `FRPEC_ADDR_ADRU)
            adr_hi <= i_wdata[7:0];
         if (i_wr && i_addr == `FRPEC_ADDR_PAGE)
            page <= i_wdata[7:0];
         if (i_wr && i_addr == `FRPEC_ADDR_IRQ_EN)
            irq_en <= i_wdata[3:0];
      end
   end

   // sequencer next state
   always_comb
   begin
      next_state = state;
      unique case (state)
         frpec_pkg::FRPEC_IDLE:
            if (go)
               next_state = i_wdata[3:0] == `FRPEC_OP_ERASE ? frpec_pkg::FRPEC_ERASE
                                                             : frpec_pkg::FRPEC_ROW;
         frpec_pkg::FRPEC_ERASE:
            if (!fl_busy && !o_fl_erase)
               next_state = frpec_pkg::FRPEC_DONE;
         frpec_pkg::FRPEC_ROW:
            if (widx == 7'h7f && !fl_busy && o_fl_prog)
               next_state = frpec_pkg::FRPEC_DONE;
         frpec_pkg::FRPEC_DONE:
            next_state = frpec_pkg::FRPEC_IDLE;
      endcase
   end

   // sequencer: erase whole block, or program row word by word
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         state      <= frpec_pkg::FRPEC_IDLE;
         widx       <= 7'h00;
         o_fl_erase <= 1'b0;
         o_fl_prog  <= 1'b0;
      end
      else
      begin
         state <= next_state;
         if (go)
         begin
            widx       <= 7'h00;
            o_fl_erase <= i_wdata[3:0] == `FRPEC_OP_ERASE;
            o_fl_prog  <= i_wdata[3:0] == `FRPEC_OP_ROW;
         end
         else if (state == frpec_pkg::FRPEC_ERASE && fl_busy)
            o_fl_erase <= 1'b0;
         else if (state == frpec_pkg::FRPEC_ROW && !fl_busy && o_fl_prog)
         begin
            widx <= widx + 7'h01;
            if (widx == 7'h7f)
               o_fl_prog <= 1'b0;
         end
      end
   end

   // word count of the running row, kept apart from widx for the checker
   always_ff @(posedge i_clk)
   begin
      if (i_rst || go)
         words_done <= 8'h00;
      else if (state == frpec_pkg::FRPEC_ROW && !fl_busy && o_fl_prog)
         words_done <= words_done + 8'h01;
   end

   // array strobes only run under their own operation code
   erase_code_a: assert property (@(posedge i_clk) disable iff (i_rst)
      o_fl_erase |-> op == `FRPEC_OP_ERASE && state == frpec_pkg::FRPEC_ERASE)
      else $error("erase strobe without erase code");
   row_code_a: assert property (@(posedge i_clk) disable iff (i_rst)
      o_fl_prog |-> op == `FRPEC_OP_ROW && state == frpec_pkg::FRPEC_ROW)
      else $error("program strobe without row code");
   // a row write hands over exactly one row of words
   row_words_a: assert property (@(posedge i_clk) disable iff (i_rst)
      $fell(o_fl_prog) |-> words_done == 8'(`FRPEC_ROW_WORDS))
      else $error("row write did not cover the row");
   // erase always targets the start of an eight-row block
   erase_base_a: assert property (@(posedge i_clk) disable iff (i_rst)
      state == frpec_pkg::FRPEC_ERASE |-> o_fl_addr[10:0] == 11'h000)
      else $error("erase address not block aligned");
   // a single error is mended quietly
   single_quiet_a: assert property (@(posedge i_clk) disable iff (i_rst)
      rd_flash && ecc_sec |=> !o_dbe_trap)
      else $error("single error raised a trap");

   // flash address: block base for erase, row word for program
   always_comb
   begin
      if (state == frpec_pkg::FRPEC_ERASE)
         o_fl_addr = {adr_hi, adr_lo[15:11], 11'h000};
      else if (state == frpec_pkg::FRPEC_ROW)
         o_fl_addr = {adr_hi, adr_lo[15:8], widx, 1'b0};
      else
         o_fl_addr = tbl_addr;
   end
   assign o_fl_wdata = latch[widx];
   assign o_fl_wpar  = ecc_par;

   // table writes fill the latches in low or high halves
   always_ff @(posedge i_clk)
   begin
      if (i_tbl_wr && to_latch && !i_tbl_high)
      begin
         if (!i_tbl_byte)
            latch[lidx][15:0] <= i_tbl_wdata;
         else if (i_tbl_ea0)
            latch[lidx][15:8] <= i_tbl_wdata[7:0];
         else
            latch[lidx][7:0] <= i_tbl_wdata[7:0];
      end
      else if (i_tbl_wr && to_latch && !(i_tbl_byte && i_tbl_ea0))
         latch[lidx][23:16] <= i_tbl_wdata[7:0];
   end

   // table read data and error reporting
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_tbl_rdata <= 16'h0000;
         o_dbe_trap  <= 1'b0;
      end
      else
      begin
         o_dbe_trap <= rd_flash && ecc_ded;
         if (i_tbl_rd && !i_tbl_high && !i_tbl_byte)
            o_tbl_rdata <= rd_word[15:0];
         else if (i_tbl_rd && !i_tbl_high)
            o_tbl_rdata <= {8'h00, i_tbl_ea0 ? rd_word[15:8] : rd_word[7:0]};
         else if (i_tbl_rd)
            o_tbl_rdata <= {8'h00, i_tbl_ea0 ? 8'h00 : rd_word[23:16]};
      end
   end

   // sticky status, set wins over clear
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         status <= 4'h0;
      else
         status <= (status & ~((i_wr && i_addr == `FRPEC_ADDR_IRQ_CLR) ? i_wdata[3:0] : 4'h0))
                   | {rd_flash && ecc_ded, rd_flash && ecc_sec, reject, seq_end};
   end
   assign o_irq   = |(status & irq_en);
   assign o_stall = state != frpec_pkg::FRPEC_IDLE;

   // register read mux, one cycle latency
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_rdata <= 16'h0000;
      else if (i_rd)
         unique case (i_addr)
            `FRPEC_ADDR_CTRL:   o_rdata <= ctrl;
            `FRPEC_ADDR_ADRL:   o_rdata <= adr_lo;
            `FRPEC_ADDR_ADRU:   o_rdata <= {8'h00, adr_hi};
            `FRPEC_ADDR_PAGE:   o_rdata <= {8'h00, page};
            `FRPEC_ADDR_STATUS: o_rdata <= {12'h000, status};
            `FRPEC_ADDR_IRQ_EN: o_rdata <= {12'h000, irq_en};
            default:            o_rdata <= 16'h0000;
         endcase
      else
         o_rdata <= 16'h0000;
   end

   // start bit never stays set after a refused start
   start_refused_a: assert property (@(posedge i_clk) disable iff (i_rst)
      reject |=> !ctrl[`FRPEC_CTRL_START_BIT] && state == frpec_pkg::FRPEC_IDLE)
      else $error("refused start began a cycle");
   // stall covers the whole cycle until the start bit clears
   stall_span_a: assert property (@(posedge i_clk) disable iff (i_rst)
      ctrl[`FRPEC_CTRL_START_BIT] |-> o_stall)
      else $error("start bit set while core not stalled");
   // a good start raises the matching array strobe
   erase_strobe_a: assert property (@(posedge i_clk) disable iff (i_rst)
      go && i_wdata[3:0] == `FRPEC_OP_ERASE |=> o_fl_erase && !o_fl_prog)
      else $error("erase code did not erase");
   row_strobe_a: assert property (@(posedge i_clk) disable iff (i_rst)
      go && i_wdata[3:0] == `FRPEC_OP_ROW |=> o_fl_prog && !o_fl_erase)
      else $error("row code did not program");
   // stray write breaks the unlock
   key_reset_a: assert property (@(posedge i_clk) disable iff (i_rst)
      i_wr && !wr_key |=> key_stage == 2'd0)
      else $error("unlock survived a stray write");
   // double error traps one cycle after the read
   dbe_trap_a: assert property (@(posedge i_clk) disable iff (i_rst)
      rd_flash && ecc_ded |=> o_dbe_trap)
      else $error("double error not trapped");
   // unlock needs the first key before the second
   key_order_a: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(unlocked) |-> $past(key_stage) == 2'd1)
      else $error("unlock without first key");
   // start bit drops as the cycle completes
   start_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
      seq_end |=> !ctrl[`FRPEC_CTRL_START_BIT] ##1 !o_stall)
      else $error("start bit not cleared at completion");
endmodule
`default_nettype wire

// ### frpec_flash_model.sv
`default_nettype none
// flash array: 24-bit words with their check bits
module frpec_flash_model
(
   // clock
   input  wire logic        i_clk,
   // sequencer side
   input  wire logic [23:0] i_addr,
   input  wire logic [23:0] i_wdata,
   input  wire logic [6:0]  i_wpar,
   input  wire logic        i_prog,
   input  wire logic        i_erase,
   output logic      [23:0] o_rdata,
   output logic      [6:0]  o_rpar,
   output logic             o_busy,
   // bench knobs: slow array, read faults
   input  wire logic        i_slow,
   input  wire logic [30:0] i_flip
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [30:0] mem [0:4095]; // parity over data
   logic [7:0]  left;         // erase cycles to go
   logic [1:0]  blk;          // block under erase
   logic [1:0]  pace;         // slow busy pattern
   logic [1:0]  seen;         // busy as the sequencer sees it, two edges late
   // faults only where the bench asks for them
   assign {o_rpar, o_rdata} = mem[i_addr[12:1]] ^ i_flip;
   assign o_busy = (left != 8'h00) || (i_slow && i_prog && pace[1]);
   initial
   begin
      left = 8'h00;
      pace = 2'h0;
      seen = 2'h0;
      for (int i = 0; i < 4096; i++)
         mem[i] = 31'h0;
   end
   // whole block to ones at end of busy, one word per free cycle
   always @(posedge i_clk)
   begin
      pace <= pace + 2'h1;
      seen <= {seen[0], o_busy};
      if (left != 8'h00)
      begin
         left <= left - 8'h01;
         if (left == 8'h01)
            for (int i = 0; i < 1024; i++)
               mem[{blk, 10'(i)}] <= 31'h7fffffff;
      end
      else if (i_erase)
      begin
         left <= 8'h14;
         blk  <= i_addr[12:11];
      end
      // a word is taken when the sequencer, through its synchroniser, sees the array free
      else if (i_prog && !seen[1])
         mem[i_addr[12:1]] <= {i_wpar, i_wdata};
   end
endmodule
`default_nettype wire

// ### flash_row_program_erase_control_bench.sv
`include "frpec_regs.svh"
`default_nettype none
// core side driven here, flash array modelled
module flash_row_program_erase_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // design ports
   logic        i_clk, i_rst, i_wr, i_rd, i_tbl_rd, i_tbl_wr, i_tbl_high, i_tbl_byte, i_tbl_ea0, i_fl_busy;
   logic [3:0]  i_addr;
   logic [15:0] i_wdata, o_rdata, i_tbl_ea, i_tbl_wdata, o_tbl_rdata;
   logic        o_stall, o_dbe_trap, o_irq, o_fl_prog, o_fl_erase;
   logic [23:0] o_fl_addr, o_fl_wdata, i_fl_rdata, fa;
   logic [6:0]  o_fl_wpar, i_fl_rpar;
   // bench state
   logic        slow, trap;
   logic [30:0] flip;
   logic [15:0] rv, lo;
   logic [7:0]  b;
   logic [23:0] exp_w [0:1023]; // expected block
   int          seed = 18678;
   int          miscompares = 0;
   int          cmp_count = 0;
   int          base;
   frpec_top u_frpec_top (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_tbl_rd, .i_tbl_wr,
      .i_tbl_high, .i_tbl_byte, .i_tbl_ea0, .i_tbl_ea, .i_tbl_wdata, .o_tbl_rdata, .o_stall, .o_dbe_trap,
      .o_irq, .o_fl_addr, .o_fl_wdata, .o_fl_wpar, .o_fl_prog, .o_fl_erase, .i_fl_rdata, .i_fl_rpar, .i_fl_busy);
   frpec_flash_model u_frpec_flash_model (.i_clk, .i_addr(o_fl_addr), .i_wdata(o_fl_wdata), .i_wpar(o_fl_wpar),
      .i_prog(o_fl_prog), .i_erase(o_fl_erase), .o_rdata(i_fl_rdata), .o_rpar(i_fl_rpar), .o_busy(i_fl_busy),
      .i_slow(slow), .i_flip(flip));
   // 25 ns clock
   initial
   begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   task automatic chk(input logic [23:0] got, input logic [23:0] want, input string what);
      cmp_count++;
      if (got !== want)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, want);
      end
   endtask
   // register write, then one idle cycle
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
      @(posedge i_clk);
   endtask
   // register read, data stands in the next cycle only
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
      @(posedge i_clk);
   endtask
   // table op, c = write, high, byte, odd byte
   task automatic tbl(input logic [3:0] c, input logic [15:0] ea, wd, output logic [15:0] d);
      {i_tbl_wr, i_tbl_high, i_tbl_byte, i_tbl_ea0} <= c;
      i_tbl_rd    <= ~c[3];
      i_tbl_ea    <= ea;
      i_tbl_wdata <= wd;
      #1 fa = o_fl_addr;
      @(posedge i_clk);
      i_tbl_wr <= 1'b0;
      i_tbl_rd <= 1'b0;
      #1 d = o_tbl_rdata;
      trap = o_dbe_trap;
      @(posedge i_clk);
   endtask
   // unlock pair, start write, two idle cycles
   task automatic start(input logic [15:0] c);
      wr(`FRPEC_ADDR_KEY, `FRPEC_KEY_FIRST);
      wr(`FRPEC_ADDR_KEY, `FRPEC_KEY_SECOND);
      wr(`FRPEC_ADDR_CTRL, c);
      repeat (2) @(posedge i_clk);
   endtask
   // stall must hold, then drop within a bound
   task automatic wait_done;
      int n;
      n = 0;
      #1 chk(o_stall, 1'b1, "stall in cycle");
      while (o_stall !== 1'b0 && n < 4000)
      begin
         @(posedge i_clk);
         #1 n++;
      end
      chk(o_stall, 1'b0, "stall released");
      @(posedge i_clk);
   endtask
   task automatic end_sim;
      $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // hang guard
   initial
   begin
      repeat (60000) @(posedge i_clk);
      miscompares++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      end_sim;
   end
   initial
   begin
      // quiet inputs, reset for 20 cycles
      i_rst = 1'b1;
      {i_wr, i_rd, i_tbl_rd, i_tbl_wr, i_tbl_high, i_tbl_byte, i_tbl_ea0, slow} = '0;
      {i_addr, i_wdata, i_tbl_ea, i_tbl_wdata, flip} = '0;
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      rd(`FRPEC_ADDR_CTRL, rv);
      chk(rv, `FRPEC_CTRL_RST, "ctrl reset");
      rd(4'hf, rv);
      chk(rv, 24'h0, "unmapped read");
      $display("test reset done");
      // bad starts: no key, stray write, enable clear
      wr(`FRPEC_ADDR_IRQ_EN, 16'h0002);
      wr(`FRPEC_ADDR_ADRU, 16'h0001);
      wr(`FRPEC_ADDR_ADRL, 16'h0a46);
      wr(`FRPEC_ADDR_CTRL, 16'hc003);
      wr(`FRPEC_ADDR_KEY, `FRPEC_KEY_FIRST);
      wr(`FRPEC_ADDR_PAGE, 16'h0000);
      wr(`FRPEC_ADDR_KEY, `FRPEC_KEY_SECOND);
      wr(`FRPEC_ADDR_CTRL, 16'hc003);
      start(16'h8003);
      #1 chk(o_stall, 1'b0, "no cycle");
      chk(o_irq, 1'b1, "refusal irq");
      @(posedge i_clk);
      rd(`FRPEC_ADDR_CTRL, rv);
      chk(rv[15], 1'b0, "start clear");
      wr(`FRPEC_ADDR_IRQ_CLR, 16'hffff);
      #1 chk(o_irq, 1'b0, "irq cleared");
      @(posedge i_clk);
      $display("test refusal done");
      // erase of the block holding 0a46
      wr(`FRPEC_ADDR_IRQ_EN, 16'h0001);
      wr(`FRPEC_ADDR_CTRL, 16'h4003);
      start(16'hc003);
      wait_done;
      rd(`FRPEC_ADDR_CTRL, rv);
      chk(rv, 24'h4003, "start self-clears");
      chk(o_irq, 1'b1, "done irq");
      for (int k = 1020; k < 2052; k += 4)
         chk(u_frpec_flash_model.mem[k][23:0], {24{k[11:10] == 2'b01}}, "erase span");
      wr(`FRPEC_ADDR_IRQ_CLR, 16'h0001);
      wr(`FRPEC_ADDR_IRQ_EN, 16'h0000);
      $display("test erase done");
      // eight rows refill the block, odd rows on a slow array
      for (int r = 0; r < 8; r++)
      begin
         base = r * 128;
         wr(`FRPEC_ADDR_PAGE, 16'h00fa);
         for (int i = 0; i < 128; i++)
         begin
            exp_w[base + i] = 24'($random(seed));
            tbl(4'b1000, 16'(2 * i), exp_w[base + i][15:0], rv);
            tbl(4'b1100, 16'(2 * i), {8'h00, exp_w[base + i][23:16]}, rv);
         end
         b = 8'($random(seed));
         tbl(4'b1011, 16'h0007, {b, b}, rv);
         exp_w[base + 3][15:8] = b;
         tbl(4'b0000, 16'h0006, 16'h0, rv);
         chk(rv, exp_w[base + 3][15:0], "latch low");
         tbl(4'b0100, 16'h0006, 16'h0, rv);
         chk(rv[7:0], exp_w[base + 3][23:16], "latch high");
         slow <= r[0];
         wr(`FRPEC_ADDR_ADRL, 16'(2048 + r * 256));
         start(16'hc002);
         wait_done;
      end
      chk(o_irq, 1'b0, "masked irq");
      rd(`FRPEC_ADDR_STATUS, rv);
      chk(rv[`FRPEC_ST_DONE], 1'b1, "done status");
      wr(`FRPEC_ADDR_PAGE, 16'h0001);
      for (int k = 0; k < 1024; k++)
      begin
         tbl(4'b0000, 16'(2048 + 2 * k), 16'h0, lo);
         chk(fa, 24'(24'h010800 + 2 * k), "table address");
         tbl(4'b0100, 16'(2048 + 2 * k), 16'h0, rv);
         chk({rv[7:0], lo}, exp_w[k], "flash readback");
      end
      $display("test rows done");
      // one flipped bit is mended, two trap
      flip <= 31'h00000010;
      tbl(4'b0000, 16'h0800, 16'h0, rv);
      chk(rv, exp_w[0][15:0], "corrected");
      chk(trap, 1'b0, "single no trap");
      flip <= 31'h00000210;
      tbl(4'b0000, 16'h0800, 16'h0, rv);
      chk(trap, 1'b1, "double trap");
      flip <= 31'h0;
      rd(`FRPEC_ADDR_STATUS, rv);
      chk(rv[3:2], 2'b11, "error status");
      $display("test ecc done");
      end_sim;
   end
endmodule
`default_nettype wire
